// file: hw/exec_core.v
// execution core for a subset of an 8-bit microcontroller instruction set
`timescale 1ns/1ps
`include "exec_core_defines.vh"

module exec_core #(
  parameter PC_W = 11,          // program counter width
  parameter STACK_DEPTH = 8,    // return stack entries
  parameter SP_W = 3            // stack pointer width
) (
  input wire ref_clk,                 // system clock, 50 MHz
  input wire sys_rst,                 // synchronous reset, active high
  input wire clk_en,                  // freezes all state while low
  output reg [PC_W-1:0] prog_addr,    // program memory address
  input wire [15:0] prog_data,        // program word, async read
  output reg [7:0] dmem_addr,         // data memory address
  input wire [7:0] dmem_rdata,        // data memory byte, async read
  output reg [7:0] dmem_wdata,        // data memory write byte
  output reg dmem_we,                 // data memory write, one cycle
  input wire irq_req,                 // pending interrupt, same clock
  output reg irq_ack,                 // interrupt taken, one cycle
  input wire wake_pin,                // wake from power-down, async pin
  output reg sys_clk_off,             // system clock gated off
  output reg wdt_clear,               // watchdog and prescaler clear pulse
  output reg instr_done,              // end of an instruction cycle
  output reg [7:0] acc,               // accumulator
  output reg [7:0] status,            // status flags
  output reg master_interrupt_enable, // global interrupt enable
  input wire [1:0] reg_addr,          // register port address
  input wire [7:0] reg_wdata,         // register port write data
  input wire reg_wr,                  // register port write strobe
  input wire reg_rd,                  // register port read strobe
  output reg [7:0] reg_rdata          // read data, cycle after strobe
);

  // each instruction takes three clocks: fetch puts the counter on the
  // program address, decode latches the word and presents the data
  // address, execute reads the data byte and commits every result.
  // the data store is read combinationally, so the operand is only
  // valid once the address from decode has settled; the write lands
  // one clock after execute, a clock later than accumulator and flags.
  // jumps and taken skips add a whole dummy cycle rather than a shorter
  // bubble: it keeps one timing shape for every cycle, at the cost of
  // two clocks more than a pipelined fetch would need.
  // the stack wraps silently; a ninth nested entry overwrites the first.
  // unknown opcodes behave as no-ops and never touch memory or flags.
  // clk_en low freezes every flop, the wake synchroniser included.

  // sequencer states: one instruction cycle is fetch, decode, execute
  localparam [1:0] S_FETCH = 2'b00;
  localparam [1:0] S_DECODE = 2'b01;
  localparam [1:0] S_EXEC = 2'b10;
  localparam [1:0] S_HALT = 2'b11;

  reg [1:0] state;              // sequencer state
  reg [PC_W-1:0] pc;            // program counter
  reg [15:0] instr;             // latched instruction word
  reg squash;                   // current cycle is a dummy cycle
  reg [PC_W-1:0] stack [0:STACK_DEPTH-1]; // return addresses
  reg [SP_W-1:0] sp;            // next free stack slot
  reg wake_s1;                  // wake synchroniser, first stage
  reg wake_s2;                  // wake synchroniser, second stage

  wire [4:0] op = instr[`OPC_MSB:`OPC_LSB];
  wire [2:0] bit_sel = instr[`BIT_MSB:`BIT_LSB];
  wire [7:0] imm = instr[`ARG_MSB:`ARG_LSB];
  wire carry = status[`ST_C];

  // one-hot mask of the selected bit
  function [7:0] bit_mask;
    input [2:0] idx;
    begin
      bit_mask = 8'h01 << idx;
    end
  endfunction

  // immediate forms take the operand from the instruction word
  function is_imm;
    input [4:0] code;
    begin
      is_imm = (code == `OP_MOV_AX) || (code == `OP_OR_AX) ||
               (code == `OP_SBC_AX) || (code == `OP_RET_AX);
    end
  endfunction

  wire [7:0] opnd = is_imm(op) ? imm : dmem_rdata;

  // subtract datapath: acc - operand - not carry, borrow in bit 8
  wire [8:0] sub_full = {1'b0, acc} - {1'b0, opnd} - {8'h00, ~carry};
  wire [4:0] sub_low = {1'b0, acc[3:0]} - {1'b0, opnd[3:0]} - {4'h0, ~carry};

  reg [7:0] res;      // result byte
  reg to_acc;         // result goes to accumulator
  reg to_mem;         // result goes to data memory
  reg upd_z;          // zero flag is updated
  reg upd_c;          // carry flag is updated
  reg new_c;          // next carry value
  reg arith;          // full subtract flag set is updated
  reg skip;           // skip the following instruction

  // the result byte is worked out for every opcode in one place, and the
  // sequencer only decides where it goes; control opcodes other than the
  // immediate return fall through to the default branch, all enables low.
  // the accumulator forms share the memory forms' datapath and differ
  // only in the destination, which keeps the rotate logic in one copy.
  // carry is read from the status byte before execute updates it, so a
  // chain of carry rotates sees each previous result.
  // result and flag selection per opcode
  always @* begin
    res = 8'h00;
    to_acc = 1'b0;
    to_mem = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    new_c = carry;
    arith = 1'b0;
    skip = 1'b0;
    case (op)
      `OP_INC, `OP_INCA: begin
        res = dmem_rdata + 8'h01;
        to_mem = (op == `OP_INC);
        to_acc = (op == `OP_INCA);       // memory left alone
        upd_z = 1'b1;
      end
      `OP_MOV_AM, `OP_MOV_AX: begin
        res = opnd;
        to_acc = 1'b1;
      end
      `OP_MOV_MA: begin
        res = acc;
        to_mem = 1'b1;
      end
      `OP_OR_AM, `OP_OR_AX, `OP_ORM: begin
        res = acc | opnd;
        to_mem = (op == `OP_ORM);
        to_acc = (op != `OP_ORM);
        upd_z = 1'b1;
      end
      `OP_RET_AX: begin
        res = imm;
        to_acc = 1'b1;
      end
      `OP_RL, `OP_RLA: begin
        res = {dmem_rdata[6:0], dmem_rdata[7]};
        to_mem = (op == `OP_RL);
        to_acc = (op == `OP_RLA);
      end
      `OP_RLC, `OP_RLCA: begin
        res = {dmem_rdata[6:0], carry};
        new_c = dmem_rdata[7];
        upd_c = 1'b1;
        to_mem = (op == `OP_RLC);
        to_acc = (op == `OP_RLCA);
      end
      `OP_RR, `OP_RRA: begin
        res = {dmem_rdata[0], dmem_rdata[7:1]};
        to_mem = (op == `OP_RR);
        to_acc = (op == `OP_RRA);
      end
      `OP_RRC, `OP_RRCA: begin
        res = {carry, dmem_rdata[7:1]};
        new_c = dmem_rdata[0];
        upd_c = 1'b1;
        to_mem = (op == `OP_RRC);
        to_acc = (op == `OP_RRCA);
      end
      `OP_SBC_AM, `OP_SBC_AX, `OP_BORROW_SUBTRACT_TO_MEMORY: begin
        res = sub_full[7:0];
        to_mem = (op == `OP_BORROW_SUBTRACT_TO_MEMORY);
        to_acc = (op != `OP_BORROW_SUBTRACT_TO_MEMORY);
        arith = 1'b1;
        upd_z = 1'b1;
        upd_c = 1'b1;
        new_c = ~sub_full[8];            // borrow means negative
      end
      `OP_SDZ, `OP_DECREMENT_SKIP_TO_ACCUMULATOR: begin
        res = dmem_rdata - 8'h01;
        to_mem = (op == `OP_SDZ);
        to_acc = (op == `OP_DECREMENT_SKIP_TO_ACCUMULATOR);       // memory kept
        skip = (res == 8'h00);
      end
      `OP_SET: begin
        res = 8'hff;
        to_mem = 1'b1;
      end
      `OP_SETB: begin
        res = dmem_rdata | bit_mask(bit_sel); // other bits kept
        to_mem = 1'b1;
      end
      default: begin
        res = 8'h00;                     // no-op and control opcodes
      end
    endcase
  end

  // the wake pin is asynchronous to the core clock; only the second
  // stage is read, so a metastable first stage never reaches the
  // sequencer. the two clocks of latency are harmless while halted.
  // the stages reset low so a released reset does not fake a wake.
  // wake pin crosses in through two flops before use
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
    end else if (clk_en) begin
      wake_s1 <= wake_pin;
      wake_s2 <= wake_s1;
    end
  end

  // the read port returns zero outside the answer cycle, so a master
  // that samples one cycle late sees an obviously wrong value instead
  // of stale data that might look plausible.
  // only the low byte of the counter is visible through the port.
  // register port read: data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_rd) begin
        case (reg_addr)
          `REG_ACC: reg_rdata <= acc;
          `REG_STATUS: reg_rdata <= status;
          `REG_CTRL: reg_rdata <= {6'h00, sys_clk_off, master_interrupt_enable};
          `REG_PC: reg_rdata <= pc[7:0];
          default: reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // software writes to the accumulator, status and enable share this
  // process with the core, because each register may only have one
  // driver; the core's assignments come later in the process and so
  // take priority when both touch a register in the same clock.
  // interrupt entry costs one extra fetch clock: the push, vector load
  // and enable clear happen there, and the fetch repeats afterwards.
  // while halted the data outputs hold their last values; only the
  // clock-off flag changes when the core wakes.
  // sequencer, program counter, stack, accumulator and flags
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= S_FETCH;
      pc <= `RST_PC;
      prog_addr <= `RST_PC;
      instr <= 16'h0000;
      squash <= 1'b0;
      sp <= {SP_W{1'b0}};
      dmem_addr <= 8'h00;
      dmem_wdata <= 8'h00;
      dmem_we <= 1'b0;
      irq_ack <= 1'b0;
      sys_clk_off <= 1'b0;
      wdt_clear <= 1'b0;
      instr_done <= 1'b0;
      acc <= `RST_ACC;
      status <= `RST_STATUS;
      master_interrupt_enable <= 1'b0;
    end else if (clk_en) begin
      dmem_we <= 1'b0;
      irq_ack <= 1'b0;
      wdt_clear <= 1'b0;
      instr_done <= 1'b0;
      // software writes land first so the core's own updates win
      if (reg_wr) begin
        case (reg_addr)
          `REG_ACC: acc <= reg_wdata;
          `REG_STATUS: status <= reg_wdata;
          `REG_CTRL: master_interrupt_enable <= reg_wdata[0];
          default: acc <= acc;
        endcase
      end
      case (state)
        S_FETCH: begin
          // interrupts are taken only at a real instruction boundary,
          // so a pending one runs before the code a return restored
          if (!squash && master_interrupt_enable && irq_req) begin
            stack[sp] <= pc;
            sp <= sp + 1'b1;
            pc <= `IRQ_VECTOR;
            prog_addr <= `IRQ_VECTOR;
            master_interrupt_enable <= 1'b0;
            irq_ack <= 1'b1;
          end else begin
            prog_addr <= pc;
            state <= S_DECODE;
          end
        end
        S_DECODE: begin
          if (squash) begin
            instr <= 16'h0000;                  // dummy cycle carries a no-op
          end else begin
            instr <= prog_data;
            pc <= pc + 1'b1;
            dmem_addr <= prog_data[`ARG_MSB:`ARG_LSB];
          end
          state <= S_EXEC;
        end
        S_EXEC: begin
          instr_done <= 1'b1;
          squash <= 1'b0;
          state <= S_FETCH;
          if (!squash) begin
            if (to_acc) begin
              acc <= res;
            end
            if (to_mem) begin
              dmem_wdata <= res;
              dmem_we <= 1'b1;
            end
            if (upd_z) begin
              status[`ST_Z] <= (res == 8'h00);
            end
            if (upd_c) begin
              status[`ST_C] <= new_c;
            end
            if (arith) begin
              status[`ST_AC] <= ~sub_low[4];
              status[`ST_OV] <= (acc[7] ^ opnd[7]) & (acc[7] ^ res[7]);
              status[`ST_SC] <= ((acc[7] ^ opnd[7]) & (acc[7] ^ res[7])) ^ res[7];
              status[`ST_CZ] <= (res == 8'h00) & status[`ST_CZ];
            end
            if (skip) begin
              squash <= 1'b1;                   // next word becomes a dummy
              pc <= pc + 1'b1;
            end
            case (op)
              `OP_JMP: begin
                pc <= instr[`JADDR_MSB:0];
                squash <= 1'b1;                 // dummy while loading
              end
              `OP_RET, `OP_RET_AX: begin
                pc <= stack[sp - 1'b1];
                sp <= sp - 1'b1;
              end
              `OP_INTERRUPT_RETURN: begin
                pc <= stack[sp - 1'b1];
                sp <= sp - 1'b1;
                master_interrupt_enable <= 1'b1;
              end
              `OP_HALT: begin
                status[`ST_PDF] <= 1'b1;
                status[`ST_TO] <= 1'b0;
                wdt_clear <= 1'b1;
                sys_clk_off <= 1'b1;
                state <= S_HALT;
              end
              default: begin
                state <= S_FETCH;
              end
            endcase
          end
        end
        S_HALT: begin
          // contents are held; only a wake or an enabled interrupt resumes
          // a pending interrupt with the enable set also ends the halt;
          // it is then taken at the next fetch, before the next word.
          // the counter already points past the halt word, so a plain
          // wake-up resumes with the following instruction.
          // the gate itself lies outside; this core keeps its own clock.
          if (wake_s2 || (master_interrupt_enable && irq_req)) begin
            sys_clk_off <= 1'b0;
            state <= S_FETCH;
          end
        end
        default: begin
          state <= S_FETCH;
        end
      endcase
    end
  end

endmodule // exec_core

// file: hw/exec_core_defines.vh
// constants for the instruction subset execution core
// How it works
// - halt sets powerdown flag, clears watchdog expiry
// - increment byte; zero flag only
// - jump loads address, two cycles, no flags
// - moves copy bytes, flags untouched
// - no-op only advances program counter
// - or into accumulator or memory, zero flag
// - return pops counter; immediate form loads accumulator
// - interrupt return pops, enables, pending serviced first
// - rotate left, bit7 into bit0, no flags
// - rotate left through carry, carry only
// - rotate right, bit0 into bit7, no flags
// - rotate right through carry, carry only
// - borrow subtract updates arithmetic flags
// - carry cleared on negative, set otherwise
// - decrement memory, skip on zero, two cycles when skipping
// - accumulator decrement form, memory kept, skip zero
// - byte set writes all ones, no flags
// - bit set forces only selected bit
// - halt stops execution, clock off, watchdog cleared
`ifndef EXEC_CORE_DEFINES_VH
`define EXEC_CORE_DEFINES_VH

// instruction word fields
`define OPC_MSB 15
`define OPC_LSB 11
`define BIT_MSB 10
`define BIT_LSB 8
`define ARG_MSB 7
`define ARG_LSB 0
`define JADDR_MSB 10

// opcodes
`define OP_NOP 5'h00
`define OP_HALT 5'h01
`define OP_INC 5'h02
`define OP_INCA 5'h03
`define OP_JMP 5'h04
`define OP_MOV_AM 5'h05
`define OP_MOV_AX 5'h06
`define OP_MOV_MA 5'h07
`define OP_OR_AM 5'h08
`define OP_OR_AX 5'h09
`define OP_ORM 5'h0a
`define OP_RET 5'h0b
`define OP_RET_AX 5'h0c
`define OP_INTERRUPT_RETURN 5'h0d
`define OP_RL 5'h0e
`define OP_RLA 5'h0f
`define OP_RLC 5'h10
`define OP_RLCA 5'h11
`define OP_RR 5'h12
`define OP_RRA 5'h13
`define OP_RRC 5'h14
`define OP_RRCA 5'h15
`define OP_SBC_AM 5'h16
`define OP_SBC_AX 5'h17
`define OP_BORROW_SUBTRACT_TO_MEMORY 5'h18
`define OP_SDZ 5'h19
`define OP_DECREMENT_SKIP_TO_ACCUMULATOR 5'h1a
`define OP_SET 5'h1b
`define OP_SETB 5'h1c

// status byte bit positions
`define ST_C 0
`define ST_AC 1
`define ST_Z 2
`define ST_OV 3
`define ST_PDF 4
`define ST_TO 5
`define ST_SC 6
`define ST_CZ 7

// register port offsets and reset values
`define REG_ACC 2'h0
`define REG_STATUS 2'h1
`define REG_CTRL 2'h2
`define REG_PC 2'h3
`define RST_ACC 8'h00
`define RST_STATUS 8'h00
`define RST_PC 11'h000
`define IRQ_VECTOR 11'h004

`endif

// file: verification/exec_core_assertions.sv
// concurrent checks on the execution core ports
`timescale 1ns/1ps
`include "exec_core_defines.vh"
module exec_core_assertions (
  input wire ref_clk,
  input wire sys_rst,
  input wire [15:0] prog_data,
  input wire [7:0] dmem_rdata,
  input wire [7:0] dmem_wdata,
  input wire dmem_we,
  input wire irq_ack,
  input wire sys_clk_off,
  input wire wdt_clear,
  input wire instr_done,
  input wire [7:0] acc,
  input wire [7:0] status,
  input wire master_interrupt_enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  reg [4:0] op_d1; // opcode seen in the decode cycle, one stage back
  reg [4:0] op_d2; // opcode aligned with the write-back cycle
  reg [2:0] bit_d1; // bit index pipeline
  reg [2:0] bit_d2; // bit index aligned with write-back
  reg [7:0] rd_d1; // operand read in the execute cycle
  reg [7:0] acc_d1; // accumulator as seen in the execute cycle
  // align instruction and operand with the write-back edge
  always @(posedge ref_clk) begin
    op_d1 <= prog_data[`OPC_MSB:`OPC_LSB];
    op_d2 <= op_d1;
    bit_d1 <= prog_data[`BIT_MSB:`BIT_LSB];
    bit_d2 <= bit_d1;
    rd_d1 <= dmem_rdata;
    acc_d1 <= acc;
  end
  property p_inc;
    dmem_we && op_d2 == `OP_INC |-> dmem_wdata == rd_d1 + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("increment write wrong");
  property p_movma;
    dmem_we && op_d2 == `OP_MOV_MA |-> dmem_wdata == acc_d1;
  endproperty
  a_movma: assert property (p_movma) else $error("store write wrong");
  property p_rl;
    dmem_we && op_d2 == `OP_RL |-> dmem_wdata == {rd_d1[6:0], rd_d1[7]};
  endproperty
  a_rl: assert property (p_rl) else $error("rotate left write wrong");
  property p_sdz;
    dmem_we && op_d2 == `OP_SDZ |-> dmem_wdata == rd_d1 - 8'h01;
  endproperty
  a_sdz: assert property (p_sdz) else $error("decrement write wrong");
  property p_setb;
    dmem_we && op_d2 == `OP_SETB |-> dmem_wdata == (rd_d1 | (8'h01 << bit_d2));
  endproperty
  a_setb: assert property (p_setb) else $error("bit set write wrong");
  // increment, rotate-left and decrement accumulator forms must leave the data store alone
  property p_accform;
    instr_done && (op_d2 == `OP_INCA || op_d2 == `OP_RLA || op_d2 == `OP_DECREMENT_SKIP_TO_ACCUMULATOR) |-> !dmem_we;
  endproperty
  a_accform: assert property (p_accform) else $error("accumulator form wrote memory");
  property p_halt;
    $rose(sys_clk_off) |-> wdt_clear && status[`ST_PDF] && !status[`ST_TO];
  endproperty
  a_halt: assert property (p_halt) else $error("halt flags wrong");
  property p_irq;
    irq_ack |-> $past(master_interrupt_enable) && !master_interrupt_enable;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt entry enable wrong");
  property p_done;
    instr_done |=> !instr_done [*2];
  endproperty
  a_done: assert property (p_done) else $error("instruction cycle too short");
endmodule // exec_core_assertions

bind exec_core exec_core_assertions u_chk (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .prog_data(prog_data),
  .dmem_rdata(dmem_rdata),
  .dmem_wdata(dmem_wdata),
  .dmem_we(dmem_we),
  .irq_ack(irq_ack),
  .sys_clk_off(sys_clk_off),
  .wdt_clear(wdt_clear),
  .instr_done(instr_done),
  .acc(acc),
  .status(status),
  .master_interrupt_enable(master_interrupt_enable)
);

// file: verification/exec_core_mem_model.sv
// program store, data store and interrupt source around the core
`timescale 1ns/1ps
module exec_core_mem_model (
  input wire ref_clk,
  input wire [10:0] prog_addr,
  output wire [15:0] prog_data,
  input wire [7:0] dmem_addr,
  output wire [7:0] dmem_rdata,
  input wire [7:0] dmem_wdata,
  input wire dmem_we,
  input wire irq_raise,
  input wire irq_ack,
  output reg irq_req
);
  reg [15:0] pmem [0:2047]; // program words, loaded by the bench
  reg [7:0] dmem [0:255]; // data bytes
  assign prog_data = pmem[prog_addr]; // asynchronous read, as the core expects
  assign dmem_rdata = dmem[dmem_addr];
  initial irq_req = 1'b0;
  // store writes; the request level holds until the core takes it
  always @(posedge ref_clk) begin
    if (dmem_we) begin
      dmem[dmem_addr] <= dmem_wdata;
    end
    if (irq_ack) begin
      irq_req <= 1'b0;
    end else if (irq_raise) begin
      irq_req <= 1'b1;
    end
  end
endmodule // exec_core_mem_model

// file: verification/mcu_instruction_subset_exec_tb.sv
// self-checking bench running small programs through the core
`timescale 1ns/1ps
`include "exec_core_defines.vh"
module mcu_instruction_subset_exec_tb;
  reg ref_clk, sys_rst, irq_raise, wake_pin, reg_wr, reg_rd;
  reg [1:0] reg_addr;
  reg [7:0] reg_wdata;
  wire [10:0] prog_addr;
  wire [15:0] prog_data;
  wire [7:0] dmem_addr, dmem_rdata, dmem_wdata, acc, status, reg_rdata;
  wire dmem_we, irq_req, irq_ack, sys_clk_off, wdt_clear, instr_done, mie;
  integer bad_count, comparisons, i;
  exec_core u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .prog_addr(prog_addr), .prog_data(prog_data), .dmem_addr(dmem_addr),
    .dmem_rdata(dmem_rdata), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we),
    .irq_req(irq_req), .irq_ack(irq_ack), .wake_pin(wake_pin), .sys_clk_off(sys_clk_off),
    .wdt_clear(wdt_clear), .instr_done(instr_done), .acc(acc), .status(status),
    .master_interrupt_enable(mie), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  exec_core_mem_model u_mem (.ref_clk(ref_clk), .prog_addr(prog_addr), .prog_data(prog_data),
    .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata), .dmem_wdata(dmem_wdata),
    .dmem_we(dmem_we), .irq_raise(irq_raise), .irq_ack(irq_ack), .irq_req(irq_req));
  always #10 ref_clk = ~ref_clk; // 50 MHz
  function [15:0] w(input [4:0] op, input [7:0] arg);
    w = {op, 3'h0, arg};
  endfunction
  task check(input [8*12-1:0] name, input [7:0] exp, input [7:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        $display("unexpected %0s expected %h seen %h", name, exp, got);
        bad_count = bad_count + 1;
      end
    end
  endtask
  task reg_write(input [1:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task reg_read(input [1:0] a, input [7:0] exp);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 check("reg_rdata", exp, reg_rdata);
    end
  endtask
  // bounded wait for a fetch address; a miss shows up in later checks
  task wait_pc(input [10:0] p);
    begin
      for (i = 0; i < 300 && prog_addr !== p; i = i + 1) @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
    end
  endtask
  task do_reset;
    begin
      sys_rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
    end
  endtask
  task end_sim;
    begin
      if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    bad_count = bad_count + 1;
    end_sim;
  end
  initial begin
    ref_clk = 1'b0; sys_rst = 1'b1; irq_raise = 1'b0; wake_pin = 1'b0;
    reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 2'h0; reg_wdata = 8'h00;
    bad_count = 0; comparisons = 0;
    for (i = 0; i < 2048; i = i + 1) u_mem.pmem[i] = w(`OP_NOP, 8'h00);
    for (i = 0; i < 256; i = i + 1) u_mem.dmem[i] = 8'h00;
    u_mem.dmem[8'h10] = 8'h7f; u_mem.dmem[8'h11] = 8'h01; u_mem.dmem[8'h12] = 8'h81;
    u_mem.dmem[8'h13] = 8'h30; u_mem.dmem[8'h17] = 8'h01; u_mem.dmem[8'h18] = 8'h01;
    u_mem.pmem[0] = w(`OP_MOV_AX, 8'h40);
    u_mem.pmem[1] = w(`OP_INC, 8'h10);
    u_mem.pmem[2] = w(`OP_INCA, 8'h11);
    u_mem.pmem[3] = w(`OP_OR_AX, 8'h05);
    u_mem.pmem[4] = w(`OP_ORM, 8'h13);
    u_mem.pmem[5] = w(`OP_RL, 8'h12);
    u_mem.pmem[6] = w(`OP_RRA, 8'h12);
    u_mem.pmem[7] = w(`OP_MOV_MA, 8'h14);
    u_mem.pmem[8] = w(`OP_SET, 8'h15);
    u_mem.pmem[9] = {`OP_SETB, 3'h3, 8'h16};
    u_mem.pmem[10] = w(`OP_SDZ, 8'h11);
    u_mem.pmem[11] = w(`OP_MOV_AX, 8'hee); // must be skipped
    u_mem.pmem[12] = w(`OP_BORROW_SUBTRACT_TO_MEMORY, 8'h18);
    u_mem.pmem[13] = w(`OP_SBC_AX, 8'h90);
    u_mem.pmem[14] = w(`OP_DECREMENT_SKIP_TO_ACCUMULATOR, 8'h17);
    u_mem.pmem[15] = w(`OP_SET, 8'h19); // must be skipped
    u_mem.pmem[16] = w(`OP_RRCA, 8'h12);
    u_mem.pmem[17] = w(`OP_JMP, 8'h11); // park on itself
    do_reset;
    wait_pc(11'h011);
    check("inc_mem", 8'h80, u_mem.dmem[8'h10]);
    check("sdz_mem", 8'h00, u_mem.dmem[8'h11]);
    check("rl_mem", 8'h03, u_mem.dmem[8'h12]);
    check("orm_mem", 8'h37, u_mem.dmem[8'h13]);
    check("mov_mem", 8'h81, u_mem.dmem[8'h14]);
    check("set_mem", 8'hff, u_mem.dmem[8'h15]);
    check("setb_mem", 8'h08, u_mem.dmem[8'h16]);
    check("decrement_skip_to_accumulator_mem", 8'h01, u_mem.dmem[8'h17]);
    check("borrow_subtract_to_memory_mem", 8'h7f, u_mem.dmem[8'h18]);
    check("skip_mem", 8'h00, u_mem.dmem[8'h19]);
    check("acc", 8'h01, acc);
    check("carry", 8'h01, {7'h00, status[`ST_C]});
    // second program: interrupt entry, both returns, then power-down
    for (i = 0; i < 18; i = i + 1) u_mem.pmem[i] = w(`OP_NOP, 8'h00);
    u_mem.pmem[1] = w(`OP_JMP, 8'h01);
    u_mem.pmem[4] = w(`OP_RET_AX, 8'h66);
    do_reset;
    reg_write(`REG_CTRL, 8'h01);
    irq_raise <= 1'b1;
    @(posedge ref_clk);
    irq_raise <= 1'b0;
    wait_pc(11'h004);
    wait_pc(11'h001);
    check("ret_acc", 8'h66, acc);
    reg_read(`REG_CTRL, 8'h00);
    u_mem.pmem[4] = w(`OP_INTERRUPT_RETURN, 8'h00);
    reg_write(`REG_CTRL, 8'h01);
    reg_write(`REG_ACC, 8'h5a);
    irq_raise <= 1'b1;
    @(posedge ref_clk);
    irq_raise <= 1'b0;
    wait_pc(11'h004);
    wait_pc(11'h001);
    reg_read(`REG_CTRL, 8'h01);
    reg_read(`REG_ACC, 8'h5a);
    reg_write(`REG_STATUS, 8'h20);
    u_mem.pmem[1] = w(`OP_HALT, 8'h00);
    for (i = 0; i < 100 && sys_clk_off !== 1'b1; i = i + 1) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    check("clk_off", 8'h01, {7'h00, sys_clk_off});
    reg_read(`REG_STATUS, 8'h10);
    reg_read(`REG_CTRL, 8'h03);
    @(posedge ref_clk);
    wake_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check("woken", 8'h00, {7'h00, sys_clk_off});
    wake_pin <= 1'b0;
    // third program: carry rotates, memory operand forms, plain return
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    for (i = 0; i < 18; i = i + 1) u_mem.pmem[i] = w(`OP_NOP, 8'h00);
    u_mem.dmem[8'h20] = 8'h81; u_mem.dmem[8'h21] = 8'h01; u_mem.dmem[8'h22] = 8'h02;
    u_mem.dmem[8'h23] = 8'h0f; u_mem.dmem[8'h24] = 8'h40;
    u_mem.pmem[0] = w(`OP_RLC, 8'h20);
    u_mem.pmem[1] = w(`OP_RR, 8'h21);
    u_mem.pmem[2] = w(`OP_RRC, 8'h22);
    u_mem.pmem[3] = w(`OP_JMP, 8'h05); // step over the vector
    u_mem.pmem[4] = w(`OP_RET, 8'h00);
    u_mem.pmem[5] = w(`OP_RLA, 8'h24);
    u_mem.pmem[6] = w(`OP_MOV_AM, 8'h24);
    u_mem.pmem[7] = w(`OP_OR_AM, 8'h23);
    u_mem.pmem[8] = w(`OP_SBC_AM, 8'h23);
    u_mem.pmem[9] = w(`OP_RLCA, 8'h21);
    u_mem.pmem[10] = w(`OP_SBC_AX, 8'h01);
    u_mem.pmem[11] = w(`OP_JMP, 8'h0b); // park on itself
    do_reset;
    wait_pc(11'h00b);
    check("rlc_mem", 8'h02, u_mem.dmem[8'h20]);
    check("rr_mem", 8'h80, u_mem.dmem[8'h21]);
    check("rrc_mem", 8'h81, u_mem.dmem[8'h22]);
    check("rla_mem", 8'h40, u_mem.dmem[8'h24]);
    check("acc_sbc", 8'h00, acc);
    check("status_sbc", 8'h07, status);
    reg_write(`REG_CTRL, 8'h01);
    irq_raise <= 1'b1;
    @(posedge ref_clk);
    irq_raise <= 1'b0;
    wait_pc(11'h004);
    wait_pc(11'h00b);
    reg_read(`REG_CTRL, 8'h00);
    check("ret_status", 8'h07, status);
    end_sim;
  end
endmodule // mcu_instruction_subset_exec_tb
